/* src/sau_clamp.sv */
// Clamp of a wide signed value to a signed or unsigned width
`timescale 1ns/1ps
module sau_clamp (
  input  wire logic signed [63:0] value,
  input  wire logic        [5:0]  width,
  input  wire logic               uns,
  output logic             [31:0] result,
  output logic                    sat
);

  logic signed [63:0] hi;
  logic signed [63:0] lo;
  logic signed [63:0] clip;
  logic        [5:0]  wm1;

  always_comb
  begin
    wm1 = (width == 6'h00) ? 6'h00 : width - 6'h01;
    if (uns)
    begin
      lo = 64'sh0;
      hi = (64'sh1 <<< width) - 64'sh1;
    end
    else
    begin
      lo = -(64'sh1 <<< wm1);
      hi = (64'sh1 <<< wm1) - 64'sh1;
    end
    if (value < lo)
      clip = lo;
    else if (value > hi)
      clip = hi;
    else
      clip = value;
    result = clip[31:0];
    sat    = (clip != value);
  end

endmodule // sau_clamp

/* src/sau_lanes.sv */
// Lane-wise saturating add, subtract and exchange operations
`timescale 1ns/1ps
module sau_lanes (
  input  wire sau_pkg::sau_op_e op,
  input  wire logic [31:0]      a,
  input  wire logic [31:0]      b,
  output logic      [31:0]      result
);

  function automatic logic [7:0] sat8(input logic signed [8:0] v);
    if (v > 9'sh07f)
      sat8 = 8'h7f;
    else if (v < -9'sh080)
      sat8 = 8'h80;
    else
      sat8 = v[7:0];
  endfunction

  function automatic logic [15:0] sat16(input logic signed [16:0] v);
    if (v > 17'sh07fff)
      sat16 = 16'h7fff;
    else if (v < -17'sh08000)
      sat16 = 16'h8000;
    else
      sat16 = v[15:0];
  endfunction

  logic [31:0] byte_res;
  logic [31:0] half_res;
  logic [31:0] xch_res;
  logic        sub;

  assign sub = (op == sau_pkg::SAU_OP_SUBB) || (op == sau_pkg::SAU_OP_SUBH);

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_byte
      logic signed [8:0] x;
      logic signed [8:0] y;
      assign x = {a[8*g+7], a[8*g +: 8]};
      assign y = {b[8*g+7], b[8*g +: 8]};
      assign byte_res[8*g +: 8] = sat8(sub ? x - y : x + y);
    end
    for (g = 0; g < 2; g++)
    begin : g_half
      logic signed [16:0] x;
      logic signed [16:0] y;
      assign x = {a[16*g+15], a[16*g +: 16]};
      assign y = {b[16*g+15], b[16*g +: 16]};
      assign half_res[16*g +: 16] = sat16(sub ? x - y : x + y);
    end
  endgenerate

  logic signed [16:0] a_hi;
  logic signed [16:0] a_lo;
  logic signed [16:0] b_hi;
  logic signed [16:0] b_lo;

  always_comb
  begin
    a_hi = {a[31], a[31:16]};
    a_lo = {a[15], a[15:0]};
    b_hi = {b[31], b[31:16]};
    b_lo = {b[15], b[15:0]};
    if (op == sau_pkg::SAU_OP_ASX)
      xch_res = {sat16(a_hi + b_lo), sat16(a_lo - b_hi)};
    else
      xch_res = {sat16(a_hi - b_lo), sat16(a_lo + b_hi)};
    case (op)
      sau_pkg::SAU_OP_ADDB, sau_pkg::SAU_OP_SUBB: result = byte_res;
      sau_pkg::SAU_OP_ADDH, sau_pkg::SAU_OP_SUBH: result = half_res;
      default:                                    result = xch_res;
    endcase
  end

endmodule // sau_lanes

/* src/sau_pkg.sv */
// Package of constants and types for the saturating arithmetic unit
// ----------------------------------------------------------------------
// Operation
// - Signed clamp to min/max of n bits
// - Unsigned clamp to zero or 2^n-1
// - Clamping in clamps and word add/sub sets the sticky saturation flag
// - Flag holds; only status write clears it
// - Flag visible only through status read
// - Signed clamp: shift first, n 1..32
// - Unsigned clamp: shift first, n 0..31
// - Shift is right arithmetic or left logical
// - Condition flags never touched
// - Dual signed clamp per halfword, n 1..16
// - Dual unsigned clamp per halfword, n 0..15
// - Word add/sub clamped to signed 32 bits
// - Lane add/sub clamped per lane width
// - Lane add/sub never touch the flag
// - Add-sub exchange: top sum, bottom difference
// - Sub-add exchange: top difference, bottom sum
// - Condition failed: no result, no status
// ----------------------------------------------------------------------
package sau_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0]  SAU_ADDR_PSR   = 4'h0;
  localparam logic [3:0]  SAU_ADDR_IST   = 4'h4;
  localparam logic [3:0]  SAU_ADDR_IMSK  = 4'h8;
  localparam int          SAU_PSR_SAT    = 0;
  localparam int          SAU_IST_SAT    = 0;
  localparam logic [31:0] SAU_PSR_RST    = 32'h0000_0000;
  localparam logic [31:0] SAU_IST_RST    = 32'h0000_0000;
  localparam logic [31:0] SAU_IMSK_RST   = 32'h0000_0000;
  localparam logic [31:0] SAU_RES_RST    = 32'h0000_0000;
  localparam logic [5:0]  SAU_WORD_WIDTH = 6'h20;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SAU_OP_SCLAMP  = 4'h0,
    SAU_OP_UCLAMP  = 4'h1,
    SAU_OP_DSCLAMP = 4'h2,
    SAU_OP_DUCLAMP = 4'h3,
    SAU_OP_ADD32   = 4'h4,
    SAU_OP_SUB32   = 4'h5,
    SAU_OP_ADDB    = 4'h6,
    SAU_OP_SUBB    = 4'h7,
    SAU_OP_ADDH    = 4'h8,
    SAU_OP_SUBH    = 4'h9,
    SAU_OP_ASX     = 4'ha,
    SAU_OP_SAX     = 4'hb
  } sau_op_e;

  typedef struct packed {
    sau_op_e     op;
    logic        cond_ok;
    logic [5:0]  sat_n;
    logic        shift_asr;
    logic [4:0]  shift_amt;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
  } sau_req_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sau_bus_s;

endpackage

/* src/sau_unit.sv */
// Saturating arithmetic unit with sticky flag and register port
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sau_unit (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              req_valid,
  input  wire sau_pkg::sau_req_s req,
  input  wire sau_pkg::sau_bus_s bus,
  output logic            [31:0] rd_data,
  output logic            [31:0] result,
  output logic                   result_valid,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Word path: shift, add or subtract at full precision
  // ----------------------------------------------------------------------
  logic signed [63:0] src64;
  logic signed [63:0] shifted;
  logic signed [32:0] sum33;
  logic signed [63:0] word_value;
  logic        [5:0]  word_width;
  logic               word_uns;
  logic               is_arith32;
  logic        [31:0] word_res;
  logic               word_sat;

  always_comb
  begin
    src64 = {{32{req.first_operand[31]}}, req.first_operand};
    if (req.shift_asr)
      shifted = src64 >>> req.shift_amt;
    else
      shifted = src64 <<< req.shift_amt;
    is_arith32 = (req.op == sau_pkg::SAU_OP_ADD32) ||
                 (req.op == sau_pkg::SAU_OP_SUB32);
    if (req.op == sau_pkg::SAU_OP_SUB32)
      sum33 = {req.first_operand[31], req.first_operand} -
              {req.second_operand[31], req.second_operand};
    else
      sum33 = {req.first_operand[31], req.first_operand} +
              {req.second_operand[31], req.second_operand};
    if (is_arith32)
    begin
      word_value = {{31{sum33[32]}}, sum33};
      word_width = sau_pkg::SAU_WORD_WIDTH;
    end
    else
    begin
      word_value = shifted;
      word_width = req.sat_n;
    end
    word_uns = (req.op == sau_pkg::SAU_OP_UCLAMP);
  end

  sau_clamp u_word_clamp (
    .value  (word_value),
    .width  (word_width),
    .uns    (word_uns),
    .result (word_res),
    .sat    (word_sat)
  );

  // ----------------------------------------------------------------------
  // Dual halfword clamps
  // ----------------------------------------------------------------------
  logic [31:0] dual_res;
  logic [1:0]  half_sat;
  logic        dual_uns;

  assign dual_uns = (req.op == sau_pkg::SAU_OP_DUCLAMP);

  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : g_dual
      logic signed [63:0] hv;
      logic        [31:0] hr;
      assign hv = {{48{req.first_operand[16*h+15]}},
                   req.first_operand[16*h +: 16]};
      sau_clamp u_half_clamp (
        .value  (hv),
        .width  (req.sat_n),
        .uns    (dual_uns),
        .result (hr),
        .sat    (half_sat[h])
      );
      assign dual_res[16*h +: 16] = hr[15:0];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Lane operations
  // ----------------------------------------------------------------------
  logic [31:0] lane_res;

  sau_lanes u_lanes (
    .op     (req.op),
    .a      (req.first_operand),
    .b      (req.second_operand),
    .result (lane_res)
  );

  // ----------------------------------------------------------------------
  // Result select and saturation event
  // ----------------------------------------------------------------------
  logic [31:0] res_sel;
  logic        sat_sel;
  logic        exec;
  logic        sat_event;

  always_comb
  begin
    case (req.op)
      sau_pkg::SAU_OP_SCLAMP, sau_pkg::SAU_OP_UCLAMP,
      sau_pkg::SAU_OP_ADD32, sau_pkg::SAU_OP_SUB32:
      begin
        res_sel = word_res;
        sat_sel = word_sat;
      end
      sau_pkg::SAU_OP_DSCLAMP, sau_pkg::SAU_OP_DUCLAMP:
      begin
        res_sel = dual_res;
        sat_sel = |half_sat;
      end
      default:
      begin
        res_sel = lane_res;
        sat_sel = 1'b0;
      end
    endcase
    exec      = req_valid && req.cond_ok;
    sat_event = exec && sat_sel;
  end

  // ----------------------------------------------------------------------
  // Registers: next values
  // ----------------------------------------------------------------------
  logic        flag_reg;
  logic        flag_next;
  logic        ist_reg;
  logic        ist_next;
  logic        imsk_reg;
  logic        imsk_next;
  logic [31:0] result_reg;
  logic [31:0] result_next;
  logic        valid_reg;
  logic        valid_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        irq_reg;
  logic        irq_next;

  always_comb
  begin
    flag_next = flag_reg;
    if (bus.wr && bus.addr == sau_pkg::SAU_ADDR_PSR)
      flag_next = bus.wdata[sau_pkg::SAU_PSR_SAT];
    if (sat_event)
      flag_next = 1'b1;
    ist_next = ist_reg;
    if (bus.wr && bus.addr == sau_pkg::SAU_ADDR_IST &&
        bus.wdata[sau_pkg::SAU_IST_SAT])
      ist_next = 1'b0;
    if (sat_event)
      ist_next = 1'b1;
    imsk_next = imsk_reg;
    if (bus.wr && bus.addr == sau_pkg::SAU_ADDR_IMSK)
      imsk_next = bus.wdata[sau_pkg::SAU_IST_SAT];
    irq_next    = ist_next && imsk_next;
    result_next = exec ? res_sel : result_reg;
    valid_next  = exec;
    rd_next     = 32'h0000_0000;
    if (bus.rd)
    begin
      case (bus.addr)
        sau_pkg::SAU_ADDR_PSR:
          rd_next[sau_pkg::SAU_PSR_SAT] = flag_reg;
        sau_pkg::SAU_ADDR_IST:
          rd_next[sau_pkg::SAU_IST_SAT] = ist_reg;
        sau_pkg::SAU_ADDR_IMSK:
          rd_next[sau_pkg::SAU_IST_SAT] = imsk_reg;
        default:
          rd_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers: storage
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      flag_reg   <= sau_pkg::SAU_PSR_RST[sau_pkg::SAU_PSR_SAT];
      ist_reg    <= sau_pkg::SAU_IST_RST[sau_pkg::SAU_IST_SAT];
      imsk_reg   <= sau_pkg::SAU_IMSK_RST[sau_pkg::SAU_IST_SAT];
      result_reg <= sau_pkg::SAU_RES_RST;
      valid_reg  <= 1'b0;
      rd_reg     <= 32'h0000_0000;
      irq_reg    <= 1'b0;
    end
    else
    begin
      flag_reg   <= flag_next;
      ist_reg    <= ist_next;
      imsk_reg   <= imsk_next;
      result_reg <= result_next;
      valid_reg  <= valid_next;
      rd_reg     <= rd_next;
      irq_reg    <= irq_next;
    end
  end

  assign rd_data      = rd_reg;
  assign result       = result_reg;
  assign result_valid = valid_reg;
  assign irq          = irq_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic psr_wr;
  assign psr_wr = bus.wr && bus.addr == sau_pkg::SAU_ADDR_PSR;

  sequence s_sat_req;
    req_valid && req.cond_ok && sat_sel;
  endsequence

  sequence s_quiet;
    !sat_event && !psr_wr;
  endsequence

  property p_sat_sets_flag;
    @(posedge sys_clk) disable iff (!resetn)
    s_sat_req |=> flag_reg;
  endproperty
  a_sat_sets_flag: assert property (p_sat_sets_flag)
    else $error("saturation did not set flag");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (!resetn)
    s_quiet |=> flag_reg == $past(flag_reg);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag changed without cause");

  property p_flag_read;
    @(posedge sys_clk) disable iff (!resetn)
    bus.rd && bus.addr == sau_pkg::SAU_ADDR_PSR
      |=> rd_data[sau_pkg::SAU_PSR_SAT] == $past(flag_reg);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("status read returned wrong flag");

  property p_lane_no_flag;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.op inside {sau_pkg::SAU_OP_ADDB,
      sau_pkg::SAU_OP_SUBB, sau_pkg::SAU_OP_ADDH,
      sau_pkg::SAU_OP_SUBH} && !psr_wr && !flag_reg |=> !flag_reg;
  endproperty
  a_lane_no_flag: assert property (p_lane_no_flag)
    else $error("lane operation set flag");

  property p_cond_fail;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && !req.cond_ok |=> !result_valid && $stable(result);
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition wrote result");

  property p_add32_pos;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok && req.op == sau_pkg::SAU_OP_ADD32 &&
    !req.first_operand[31] && !req.second_operand[31] && sum33[31]
      |=> result == 32'h7fff_ffff ##0 flag_reg;
  endproperty
  a_add32_pos: assert property (p_add32_pos)
    else $error("word add did not clamp high");

  property p_uclamp_neg;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok && req.op == sau_pkg::SAU_OP_UCLAMP &&
    req.first_operand[31] |=> result == 32'h0000_0000 ##0 flag_reg;
  endproperty
  a_uclamp_neg: assert property (p_uclamp_neg)
    else $error("negative value not clamped to zero");

  property p_sclamp16;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok && req.op == sau_pkg::SAU_OP_SCLAMP &&
    req.sat_n == 6'h10 && req.shift_amt == 5'h00 &&
    $signed(req.first_operand) > 32'sh0000_7fff
      |=> result == 32'h0000_7fff;
  endproperty
  a_sclamp16: assert property (p_sclamp16)
    else $error("signed clamp upper bound wrong");

  property p_irq;
    @(posedge sys_clk) disable iff (!resetn)
    s_sat_req ##1 imsk_reg |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_psr_only_flag;
    @(posedge sys_clk) disable iff (!resetn)
    bus.rd && bus.addr == sau_pkg::SAU_ADDR_PSR |=> rd_data[31:1] == 31'h0;
  endproperty
  a_psr_only_flag: assert property (p_psr_only_flag)
    else $error("status read shows condition bits");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!resetn)
    psr_wr && !bus.wdata[sau_pkg::SAU_PSR_SAT] && !sat_event |=> !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("status write did not clear flag");

  property p_exec_valid;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok |=> result_valid;
  endproperty
  a_exec_valid: assert property (p_exec_valid)
    else $error("executed operation gave no result");

  property p_sub32_neg;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok && req.op == sau_pkg::SAU_OP_SUB32 &&
    req.first_operand[31] && !req.second_operand[31] && !sum33[31]
      |=> result == 32'h8000_0000 ##0 flag_reg;
  endproperty
  a_sub32_neg: assert property (p_sub32_neg)
    else $error("word subtract did not clamp low");

  property p_dual_uns_neg;
    @(posedge sys_clk) disable iff (!resetn)
    req_valid && req.cond_ok && req.op == sau_pkg::SAU_OP_DUCLAMP &&
    req.first_operand[31] |=> result[31:16] == 16'h0000 ##0 flag_reg;
  endproperty
  a_dual_uns_neg: assert property (p_dual_uns_neg)
    else $error("negative top half not clamped to zero");

endmodule // sau_unit

/* verification/sau_dec_model.sv */
// Model of the instruction decoder and register file beside the unit
`timescale 1ns/1ps
module sau_dec_model (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              issue,
  input  wire sau_pkg::sau_req_s issue_req,
  input  wire logic       [31:0] result,
  input  wire logic              result_valid,
  output logic                   req_valid,
  output sau_pkg::sau_req_s      req,
  output logic            [31:0] dest_reg,
  output logic            [31:0] wr_count
);
  sau_pkg::sau_req_s idle_q = '0;

  // Idle operand lines toggle each cycle so no stale request is seen
  assign req_valid = issue;
  assign req       = issue ? issue_req : idle_q;

  always_ff @(posedge sys_clk)
  begin
    idle_q <= sau_pkg::sau_req_s'(~req);
    if (!resetn)
    begin
      dest_reg <= 32'h0;
      wr_count <= 32'h0;
    end
    else if (result_valid)
    begin
      dest_reg <= result;
      wr_count <= wr_count + 32'h1;
    end
  end
endmodule // sau_dec_model

/* verification/sau_unit_tb.sv */
// Self-checking testbench of the saturating arithmetic unit
`timescale 1ns/1ps
module sau_unit_tb;
  typedef struct packed {
    logic [3:0]  op;
    logic [5:0]  n;
    logic        arithmetic_right_shift;
    logic [4:0]  amt;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] exp;
    logic        sat;
  } sau_row_s;

  logic              sys_clk   = 1'b0;
  logic              resetn    = 1'b0;
  logic              issue     = 1'b0;
  sau_pkg::sau_req_s issue_req = '0;
  sau_pkg::sau_bus_s bus       = '0;
  sau_pkg::sau_req_s req;
  logic [31:0]       rd_data;
  logic [31:0]       result;
  logic [31:0]       dest_reg;
  logic [31:0]       wr_count;
  logic [31:0]       rv;
  logic [31:0]       cnt0;
  logic              result_valid;
  logic              irq;
  logic              req_valid;
  int                failures  = 0;
  int                cmp_count = 0;

  // ----------------------------------------------------------------------
  // Ordinary cases: operation, width, shift, operands, result, flag
  // ----------------------------------------------------------------------
  sau_row_s rows [21] = '{
    '{4'h0, 6'h08, 1'b0, 5'h00, 32'h100, 32'h0, 32'h7f, 1'b1},
    '{4'h0, 6'h08, 1'b0, 5'h00, 32'hffffff00, 32'h0, 32'hffffff80, 1'b1},
    '{4'h0, 6'h10, 1'b0, 5'h04, 32'h800, 32'h0, 32'h7fff, 1'b1},
    '{4'h0, 6'h20, 1'b1, 5'h04, 32'h80000000, 32'h0, 32'hf8000000, 1'b0},
    '{4'h1, 6'h07, 1'b0, 5'h00, 32'hfffffff0, 32'h0, 32'h0, 1'b1},
    '{4'h1, 6'h00, 1'b0, 5'h00, 32'h1, 32'h0, 32'h0, 1'b1},
    '{4'h1, 6'h1f, 1'b0, 5'h01, 32'h40000000, 32'h0, 32'h7fffffff, 1'b1},
    '{4'h1, 6'h07, 1'b0, 5'h00, 32'h7f, 32'h0, 32'h7f, 1'b0},
    '{4'h2, 6'h09, 1'b0, 5'h00, 32'h0100fe00, 32'h0, 32'h00ffff00, 1'b1},
    '{4'h3, 6'h0f, 1'b0, 5'h00, 32'h80007fff, 32'h0, 32'h7fff, 1'b1},
    '{4'h4, 6'h00, 1'b0, 5'h00, 32'h7fffffff, 32'h1, 32'h7fffffff, 1'b1},
    '{4'h5, 6'h00, 1'b0, 5'h00, 32'h80000000, 32'h1, 32'h80000000, 1'b1},
    '{4'h4, 6'h00, 1'b0, 5'h00, 32'h5, 32'h3, 32'h8, 1'b0},
    '{4'h6, 6'h00, 1'b0, 5'h00, 32'h7f800102, 32'h01800203, 32'h7f800305, 1'b0},
    '{4'h7, 6'h00, 1'b0, 5'h00, 32'h807f0500, 32'h01ff0601, 32'h807fffff, 1'b0},
    '{4'h8, 6'h00, 1'b0, 5'h00, 32'h7fff8000, 32'h0001ffff, 32'h7fff8000, 1'b0},
    '{4'h9, 6'h00, 1'b0, 5'h00, 32'h80000005, 32'h00010007, 32'h8000fffe, 1'b0},
    '{4'ha, 6'h00, 1'b0, 5'h00, 32'h00100020, 32'h00030005, 32'h0015001d, 1'b0},
    '{4'hb, 6'h00, 1'b0, 5'h00, 32'h00100020, 32'h00030005, 32'h000b0023, 1'b0},
    '{4'ha, 6'h00, 1'b0, 5'h00, 32'h7fff8000, 32'h00010001, 32'h7fff8000, 1'b0},
    '{4'h0, 6'h10, 1'b0, 5'h00, 32'h12345, 32'h0, 32'h7fff, 1'b1}
  };

  sau_unit u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .bus(bus), .rd_data(rd_data), .result(result),
    .result_valid(result_valid), .irq(irq)
  );

  sau_dec_model u_dec (
    .sys_clk(sys_clk), .resetn(resetn), .issue(issue),
    .issue_req(issue_req), .result(result), .result_valid(result_valid),
    .req_valid(req_valid), .req(req), .dest_reg(dest_reg),
    .wr_count(wr_count)
  );

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic sau_pkg::sau_req_s mk(input sau_row_s r, input logic ok);
    return {r.op, ok, r.n, r.arithmetic_right_shift, r.amt, r.a, r.b};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic run_op(input sau_pkg::sau_req_s r, input logic v);
    @(posedge sys_clk);
    issue     <= 1'b1;
    issue_req <= r;
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
    chk(32'(result_valid), 32'(v));
  endtask

  task automatic irq_is(input logic v);
    @(posedge sys_clk);
    #1;
    chk(32'(irq), 32'(v));
  endtask

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk(result, 32'h0);
    chk(32'(irq), 32'h0);
    chk(rd_data, 32'h0);
    chk(32'(result_valid), 32'h0);
    for (int k = 0; k < 16; k += 4)
    begin
      bus_rd(4'(k), rv);
      chk(rv, 32'h0);
    end
    bus_wr(4'hc, 32'hffffffff);
    bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
    chk(rv, 32'h0);
    foreach (rows[i])
    begin
      bus_wr(sau_pkg::SAU_ADDR_PSR, 32'h0);
      run_op(mk(rows[i], 1'b1), 1'b1);
      chk(result, rows[i].exp);
      bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
      chk(rv, 32'(rows[i].sat));
      chk(dest_reg, rows[i].exp);
    end
    // Sticky flag survives plain and lane operations
    run_op(mk(rows[0], 1'b1), 1'b1);
    run_op(mk(rows[12], 1'b1), 1'b1);
    run_op(mk(rows[13], 1'b1), 1'b1);
    bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
    chk(rv, 32'h1);
    bus_wr(sau_pkg::SAU_ADDR_PSR, 32'h0);
    bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
    chk(rv, 32'h0);
    // Failed condition leaves result, writes and flag alone
    cnt0 = wr_count;
    run_op(mk(rows[0], 1'b0), 1'b0);
    chk(result, rows[13].exp);
    chk(wr_count, cnt0);
    bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
    chk(rv, 32'h0);
    // Interrupt raised, cleared, masked
    bus_wr(sau_pkg::SAU_ADDR_IST, 32'h1);
    bus_wr(sau_pkg::SAU_ADDR_IMSK, 32'h1);
    irq_is(1'b0);
    run_op(mk(rows[10], 1'b1), 1'b1);
    irq_is(1'b1);
    bus_wr(sau_pkg::SAU_ADDR_IST, 32'h1);
    irq_is(1'b0);
    bus_wr(sau_pkg::SAU_ADDR_IMSK, 32'h0);
    run_op(mk(rows[11], 1'b1), 1'b1);
    irq_is(1'b0);
    bus_rd(sau_pkg::SAU_ADDR_IST, rv);
    chk(rv, 32'h1);
    bus_wr(sau_pkg::SAU_ADDR_IMSK, 32'h1);
    irq_is(1'b1);
    bus_wr(sau_pkg::SAU_ADDR_IST, 32'h1);
    irq_is(1'b0);
    // Back-to-back requests
    @(posedge sys_clk);
    issue     <= 1'b1;
    issue_req <= mk(rows[11], 1'b1);
    @(posedge sys_clk);
    issue_req <= mk(rows[17], 1'b1);
    #1;
    chk(result, rows[11].exp);
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
    chk(result, rows[17].exp);
    chk(32'(result_valid), 32'h1);
    // Reset in mid-run clears the flag and the result
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    bus_rd(sau_pkg::SAU_ADDR_PSR, rv);
    chk(rv, 32'h0);
    chk(result, 32'h0);
    print_verdict();
  end
endmodule // sau_unit_tb
